/* inc/pwrmc_pkg.sv */
/*
 * Shared constants and types for the power mode controller.
 * Assumes a single 10 MHz system clock and an active high asynchronous reset.
 */
package pwrmc_pkg;

    // ==========================================================
    // Power modes
    typedef enum logic [1:0] {
        active_mode,
        light_sleep_mode,
        retention_sleep_mode,
        deepest_sleep_mode
    } pwrmc_mode_t;

    // ==========================================================
    // High frequency oscillator selection in active mode
    localparam logic [1:0] HF_SEL_RC   = 2'h1;
    localparam logic [1:0] HF_SEL_XO   = 2'h2;
    localparam logic [1:0] HF_SEL_BOTH = 2'h3;

    // ==========================================================
    // Sleep timer
    localparam int             TMR_W     = 24;
    localparam logic [23:0]    TMR_RESET = 24'h000000;
    localparam logic [23:0]    TMR_STEP  = 24'h000001;

    // ==========================================================
    // Memory sizes in bytes
    localparam int SRAM_TOTAL_BYTES = 8192;
    localparam int SRAM_RET_BYTES   = 4096;

    // ==========================================================
    // Wake cause bit positions
    localparam int CAUSE_EXT = 0;
    localparam int CAUSE_TMR = 1;
    localparam int CAUSE_IRQ = 2;
    localparam int CAUSE_W   = 3;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYNC_STAGES   = 2;
    localparam int SYNC_INPUTS   = 2;
    localparam int SYNC_EXT      = 0;
    localparam int SYNC_LF       = 1;

endpackage

/* inc/pwrmc_tmr_if.sv */
/*
 * Carrier between the mode controller and its sleep timer.
 * Assumes both ends run on the same system clock.
 */
interface pwrmc_tmr_if;
    import pwrmc_pkg::*;

    logic             run;
    logic             tick;
    logic [TMR_W-1:0] cmp;
    logic [TMR_W-1:0] count;
    logic             expire;

    modport ctrl (output run, output tick, output cmp, input count, input expire);
    modport tmr  (input run, input tick, input cmp, output count, output expire);

endinterface

/* tb/tb.sv */
/*
 * Self-checking testbench for the power mode controller top module.
 * Assumes the package and the design files are compiled first; drives every input itself.
 */
module tb
    import pwrmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Stimulus and observed signals
    logic             clk_i           = 1'b0;
    logic             rst_i           = 1'b1;
    logic             sleep_req_i     = 1'b0;
    logic [1:0]       sleep_mode_i    = 2'h0;
    logic [1:0]       hf_sel_i        = 2'h1;
    logic             lf_xosc_sel_i   = 1'b0;
    logic             ext_int_i       = 1'b0;
    logic             lf_clk_i        = 1'b0;
    logic             irq_pend_i      = 1'b0;
    logic [TMR_W-1:0] sleep_cmp_i     = 24'hffffff;
    logic             sram_lost_clr_i = 1'b0;
    logic [1:0]       power_mode_o;
    logic             dreg_en_o;
    logic             hf_rcosc_en_o;
    logic             hf_xosc_en_o;
    logic             lf_rcosc_en_o;
    logic             lf_xosc_en_o;
    logic             sram_ret_en_o;
    logic             sram_main_en_o;
    logic             sram_lost_o;
    logic [TMR_W-1:0] sleep_count_o;
    logic             wake_o;
    logic [CAUSE_W-1:0] wake_cause_o;
    int               fail_count = 0;
    int               cmp_count  = 0;
    int               cyc        = 0;
    logic [TMR_W-1:0] exp_count  = 24'h000000;

    pwrmc_ctrl i_pwrmc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req_i),
        .sleep_mode_i(sleep_mode_i), .hf_sel_i(hf_sel_i), .lf_xosc_sel_i(lf_xosc_sel_i),
        .ext_int_i(ext_int_i), .lf_clk_i(lf_clk_i), .irq_pend_i(irq_pend_i),
        .sleep_cmp_i(sleep_cmp_i), .sram_lost_clr_i(sram_lost_clr_i),
        .power_mode_o(power_mode_o), .dreg_en_o(dreg_en_o), .hf_rcosc_en_o(hf_rcosc_en_o),
        .hf_xosc_en_o(hf_xosc_en_o), .lf_rcosc_en_o(lf_rcosc_en_o),
        .lf_xosc_en_o(lf_xosc_en_o), .sram_ret_en_o(sram_ret_en_o),
        .sram_main_en_o(sram_main_en_o), .sram_lost_o(sram_lost_o),
        .sleep_count_o(sleep_count_o), .wake_o(wake_o), .wake_cause_o(wake_cause_o));

    // ==========================================================
    // Clock and hang guard
    always #50 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Inputs move 10 ns after the edge so the design never races the bench.
    task automatic step();
        @(posedge clk_i);
        #10;
    endtask

    task automatic chk_en(input logic [1:0] m);
        logic on;
        on = (m != 2'h3);
        chk("power_mode", power_mode_o, m);
        chk("dreg_en", dreg_en_o, m <= 2'h1);
        chk("hf_rc", hf_rcosc_en_o, m == 2'h0 && hf_sel_i != HF_SEL_XO);
        chk("hf_xo", hf_xosc_en_o, m == 2'h0 && hf_sel_i[1]);
        chk("lf_rc", lf_rcosc_en_o, on && !lf_xosc_sel_i);
        chk("lf_xo", lf_xosc_en_o, on && lf_xosc_sel_i);
        chk("sram_ret", sram_ret_en_o, 1'b1);
        chk("sram_main", sram_main_en_o, m <= 2'h1);
    endtask

    task automatic req(input logic [1:0] m);
        sleep_mode_i = m;
        sleep_req_i  = 1'b1;
        step();
        sleep_req_i  = 1'b0;
    endtask

    task automatic wait_wake(input int lat, input logic [2:0] cause);
        int n;
        n = 0;
        do begin
            step();
            n++;
        end while (wake_o !== 1'b1 && n < 10);
        chk("wake_lat", n[23:0], lat[23:0]);
        chk("wake_cause", wake_cause_o, cause);
        chk_en(2'h0);
        step();
        chk("wake_pulse", wake_o, 1'b0);
    endtask

    // Edges stay four clocks apart, more than the three clocks a rising edge needs to reach the sleep count.
    task automatic lf_tick();
        lf_clk_i = 1'b1;
        repeat (4) step();
        lf_clk_i = 1'b0;
        repeat (4) step();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_and_hf();
        chk_en(2'h0);
        chk("sram_lost", sram_lost_o, 1'b0);
        chk("count", sleep_count_o, 24'h000000);
        for (int h = 0; h < 4; h++) begin
            hf_sel_i = h[1:0];
            repeat (2) step();
            chk_en(2'h0);
        end
        hf_sel_i = 2'h1;
        req(2'h0);
        repeat (3) step();
        chk("stay_active", power_mode_o, 2'h0);
    endtask

    task automatic t_light_ext();
        lf_xosc_sel_i = 1'b1;
        repeat (2) step();
        req(2'h1);
        chk_en(2'h1);
        chk("sram_lost", sram_lost_o, 1'b0);
        // A clock edge must pass so the request strobe is not lowered and raised at once.
        step();
        req(2'h3);
        chk("no_rerequest", power_mode_o, 2'h1);
        ext_int_i = 1'b1;
        wait_wake(3, 3'h1);
        ext_int_i = 1'b0;
        lf_xosc_sel_i = 1'b0;
        repeat (4) step();
    endtask

    task automatic t_retention_timer();
        lf_tick();
        exp_count = exp_count + 24'h1;
        chk("count_active", sleep_count_o, exp_count);
        sleep_cmp_i = exp_count + 24'h1;
        req(2'h2);
        chk_en(2'h2);
        chk("sram_lost", sram_lost_o, 1'b1);
        lf_clk_i = 1'b1;
        wait_wake(4, 3'h2);
        exp_count = exp_count + 24'h1;
        chk("count_wake", sleep_count_o, exp_count);
        lf_clk_i = 1'b0;
        sleep_cmp_i = 24'hffffff;
        sram_lost_clr_i = 1'b1;
        step();
        sram_lost_clr_i = 1'b0;
        step();
        chk("sram_lost_clr", sram_lost_o, 1'b0);
    endtask

    task automatic t_deepest();
        sleep_cmp_i = exp_count + 24'h1;
        req(2'h3);
        chk_en(2'h3);
        lf_tick();
        lf_tick();
        chk("count_frozen", sleep_count_o, exp_count);
        chk("no_timer_wake", power_mode_o, 2'h3);
        ext_int_i = 1'b1;
        wait_wake(3, 3'h1);
        ext_int_i = 1'b0;
        sleep_cmp_i = 24'hffffff;
        repeat (4) step();
    endtask

    // The timer must keep counting in light sleep and wake it on a match.
    task automatic t_light_timer();
        sleep_cmp_i = exp_count + 24'h1;
        req(2'h1);
        chk("asleep_light", power_mode_o, 2'h1);
        lf_clk_i = 1'b1;
        wait_wake(4, 3'h2);
        exp_count = exp_count + 24'h1;
        chk("count_light", sleep_count_o, exp_count);
        lf_clk_i = 1'b0;
        sleep_cmp_i = 24'hffffff;
        repeat (4) step();
    endtask

    task automatic t_irq_all();
        for (int m = 1; m < 4; m++) begin
            req(m[1:0]);
            chk("asleep", power_mode_o, m[1:0]);
            irq_pend_i = 1'b1;
            wait_wake(1, 3'h4);
            irq_pend_i = 1'b0;
            step();
        end
    endtask

    // Reset is itself a wake path, so it is taken from retention sleep.
    task automatic t_reset_wake();
        req(2'h2);
        rst_i = 1'b1;
        step();
        chk_en(2'h0);
        chk("count_rst", sleep_count_o, 24'h000000);
        rst_i = 1'b0;
        exp_count = 24'h000000;
        step();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        #10;
        rst_i = 1'b0;
        t_reset_and_hf();
        t_light_ext();
        t_retention_timer();
        t_deepest();
        t_light_timer();
        t_irq_all();
        t_reset_wake();
        report_and_stop();
    end

endmodule // tb

/* verilog/pwrmc_ctrl.sv */
/*
 * Power mode controller: holds the current power mode, drives regulator,
 * oscillator and memory power enables, and wakes the system.
 * Assumes software raises sleep_req_i for one clock with the mode on
 * sleep_mode_i, and that ext_int_i and lf_clk_i are asynchronous pins.
 */
module pwrmc_ctrl
    import pwrmc_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               sleep_req_i,
    input  wire logic [1:0]         sleep_mode_i,
    input  wire logic [1:0]         hf_sel_i,
    input  wire logic               lf_xosc_sel_i,
    input  wire logic               ext_int_i,
    input  wire logic               lf_clk_i,
    input  wire logic               irq_pend_i,
    input  wire logic [TMR_W-1:0]   sleep_cmp_i,
    input  wire logic               sram_lost_clr_i,
    output logic [1:0]              power_mode_o,
    output logic                    dreg_en_o,
    output logic                    hf_rcosc_en_o,
    output logic                    hf_xosc_en_o,
    output logic                    lf_rcosc_en_o,
    output logic                    lf_xosc_en_o,
    output logic                    sram_ret_en_o,
    output logic                    sram_main_en_o,
    output logic                    sram_lost_o,
    output logic [TMR_W-1:0]        sleep_count_o,
    output logic                    wake_o,
    output logic [CAUSE_W-1:0]      wake_cause_o
);

    // ==========================================================
    // Mode decoding
    function automatic logic dreg_on(input pwrmc_mode_t m);
        return (m == active_mode) || (m == light_sleep_mode);
    endfunction

    function automatic logic hf_on(input pwrmc_mode_t m);
        return m == active_mode;
    endfunction

    function automatic logic lf_on(input pwrmc_mode_t m);
        return m != deepest_sleep_mode;
    endfunction

    // ==========================================================
    // Declarations
    pwrmc_mode_t                mode;
    pwrmc_mode_t                next_mode;
    pwrmc_mode_t                req_mode;
    logic [SYNC_INPUTS-1:0]     sync_s1;
    logic [SYNC_INPUTS-1:0]     sync_s2;
    logic [SYNC_INPUTS-1:0]     pin_in;
    logic                       ext_sync;
    logic                       lf_sync;
    logic                       lf_prev;
    logic                       lf_sel;
    logic                       next_lf_sel;
    logic [CAUSE_W-1:0]         next_cause;
    logic                       waking;

    pwrmc_tmr_if                tmr_bus ();

    // ==========================================================
    // Pin synchronisers
    assign pin_in[SYNC_EXT] = ext_int_i;
    assign pin_in[SYNC_LF]  = lf_clk_i;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_INPUTS; gi++) begin : g_sync
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    sync_s1[gi] <= 1'b0;
                    sync_s2[gi] <= 1'b0;
                end else begin
                    sync_s1[gi] <= pin_in[gi];
                    sync_s2[gi] <= sync_s1[gi];
                end
            end
        end
    endgenerate

    assign ext_sync = sync_s2[SYNC_EXT];
    assign lf_sync  = sync_s2[SYNC_LF];

    // The LF clock is sampled rather than used as a clock, so one tick per rising edge.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lf_prev <= 1'b0;
        end else begin
            lf_prev <= lf_sync;
        end
    end

    // ==========================================================
    // Sleep timer
    assign tmr_bus.run  = lf_on(mode);
    assign tmr_bus.tick = lf_sync && !lf_prev;
    assign tmr_bus.cmp  = sleep_cmp_i;

    pwrmc_sleep_timer u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tmr   (tmr_bus)
    );

    assign sleep_count_o = tmr_bus.count;

    // ==========================================================
    // Mode sequencing
    assign req_mode = pwrmc_mode_t'(sleep_mode_i);

    always_comb begin
        next_mode  = mode;
        next_cause = '0;
        unique case (mode)
            active_mode: begin
                if (sleep_req_i && (req_mode != active_mode)) begin
                    next_mode = req_mode;
                end
            end
            light_sleep_mode, retention_sleep_mode: begin
                next_cause[CAUSE_EXT] = ext_sync;
                next_cause[CAUSE_TMR] = tmr_bus.expire;
                next_cause[CAUSE_IRQ] = irq_pend_i;
                if (|next_cause) begin
                    next_mode = active_mode;
                end
            end
            deepest_sleep_mode: begin
                // The timer is stopped here, so only the ext_int_i pin and interrupts can wake.
                next_cause[CAUSE_EXT] = ext_sync;
                next_cause[CAUSE_IRQ] = irq_pend_i;
                if (|next_cause) begin
                    next_mode = active_mode;
                end
            end
        endcase
    end

    assign waking = (mode != active_mode) && (next_mode == active_mode);

    // Reset always lands in active mode, which is also the wake-by-reset path.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= active_mode;
        end else begin
            mode <= next_mode;
        end
    end

    assign power_mode_o = mode;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_o       <= 1'b0;
            wake_cause_o <= '0;
        end else begin
            wake_o <= waking;
            if (waking) begin
                wake_cause_o <= next_cause;
            end
        end
    end

    // ==========================================================
    // Regulator and oscillator enables
    // The LF choice is frozen outside active mode so a sleeping system never swaps sources.
    assign next_lf_sel = (mode == active_mode) ? lf_xosc_sel_i : lf_sel;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lf_sel        <= 1'b0;
            lf_rcosc_en_o <= 1'b1;
            lf_xosc_en_o  <= 1'b0;
        end else begin
            lf_sel        <= next_lf_sel;
            lf_rcosc_en_o <= lf_on(next_mode) && !next_lf_sel;
            lf_xosc_en_o  <= lf_on(next_mode) && next_lf_sel;
        end
    end

    // A zero selection falls back to the RC oscillator so active mode never runs without one.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hf_rcosc_en_o <= 1'b1;
            hf_xosc_en_o  <= 1'b0;
        end else begin
            hf_rcosc_en_o <= hf_on(next_mode) && (hf_sel_i != HF_SEL_XO);
            hf_xosc_en_o  <= hf_on(next_mode) && hf_sel_i[1];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dreg_en_o <= 1'b1;
        end else begin
            dreg_en_o <= dreg_on(next_mode);
        end
    end

    // ==========================================================
    // SRAM retention
    // The retained half sits on its own always-on supply and is never switched here.
    assign sram_ret_en_o = 1'b1;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sram_main_en_o <= 1'b1;
        end else begin
            sram_main_en_o <= dreg_on(next_mode);
        end
    end

    // Set wins over a clear in the same cycle so a power-off is never missed.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sram_lost_o <= 1'b0;
        end else if (dreg_on(mode) && !dreg_on(next_mode)) begin
            sram_lost_o <= 1'b1;
        end else if (sram_lost_clr_i) begin
            sram_lost_o <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    mode_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (power_mode_o == 2'h0) == (hf_rcosc_en_o || hf_xosc_en_o))
        else $error("HF oscillators not tied to active mode");

    active_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == active_mode) |-> dreg_en_o && (hf_rcosc_en_o || hf_xosc_en_o))
        else $error("active mode without regulator or HF clock");

    hf_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (next_mode == active_mode && hf_sel_i == HF_SEL_BOTH)
        |=> hf_rcosc_en_o && hf_xosc_en_o)
        else $error("both HF oscillators requested but not running");

    lf_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode != deepest_sleep_mode) |-> (lf_rcosc_en_o ^ lf_xosc_en_o))
        else $error("not exactly one LF source running");

    light_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == light_sleep_mode) |-> dreg_en_o && !hf_rcosc_en_o && !hf_xosc_en_o)
        else $error("light sleep enables wrong");

    light_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode inside {light_sleep_mode, retention_sleep_mode} && (ext_sync || tmr_bus.expire))
        |=> (mode == active_mode) && wake_o && dreg_en_o)
        else $error("lighter sleep did not wake on pin or timer");

    ret_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == retention_sleep_mode)
        |-> !dreg_en_o && !hf_rcosc_en_o && !hf_xosc_en_o && (lf_rcosc_en_o || lf_xosc_en_o))
        else $error("retention sleep enables wrong");

    deep_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == deepest_sleep_mode)
        |-> !(dreg_en_o || hf_rcosc_en_o || hf_xosc_en_o || lf_rcosc_en_o || lf_xosc_en_o))
        else $error("deepest sleep left something powered");

    deep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == deepest_sleep_mode && !ext_sync && !irq_pend_i) |=> mode == deepest_sleep_mode)
        else $error("deepest sleep woke without a pin or interrupt");

    sram_lose_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == active_mode && sleep_req_i
         && req_mode inside {retention_sleep_mode, deepest_sleep_mode})
        |=> sram_lost_o && !sram_main_en_o && sram_ret_en_o ##1 sram_ret_en_o)
        else $error("SRAM power not handled on regulator off");

    irq_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode != active_mode && irq_pend_i) |=> (mode == active_mode) && wake_cause_o[CAUSE_IRQ])
        else $error("interrupt did not wake the device");

    stay_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == active_mode && !sleep_req_i) |=> (mode == active_mode) [*2] or
        (mode == active_mode && sleep_req_i))
        else $error("left active mode without a request");

endmodule // pwrmc_ctrl

/* verilog/pwrmc_sleep_timer.sv */
/*
 * Sleep timer: counts low frequency source periods and flags a compare match.
 * Assumes tick is a one-cycle pulse per low frequency period on clk_i.
 */
module pwrmc_sleep_timer
    import pwrmc_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    pwrmc_tmr_if.tmr   tmr
);

    // ==========================================================
    // Counter
    logic [TMR_W-1:0] next_count;

    assign next_count = tmr.count + TMR_STEP;

    // The count keeps running through compare matches so it doubles as a real-time counter, except in deepest sleep where it stops.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr.count <= TMR_RESET;
        end else if (tmr.run && tmr.tick) begin
            tmr.count <= next_count;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr.expire <= 1'b0;
        end else begin
            tmr.expire <= tmr.run && tmr.tick && (next_count == tmr.cmp);
        end
    end

    // ==========================================================
    // Checks
    count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(tmr.run && tmr.tick) |=> $stable(tmr.count))
        else $error("sleep count moved without a running tick");

    count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tmr.run && tmr.tick) |=> tmr.count == $past(tmr.count) + TMR_STEP)
        else $error("sleep count did not step by one");

endmodule // pwrmc_sleep_timer
